// file: src/mgipc_params.svh
// Register offsets, field positions, reset values and timing counts for the control bank
`ifndef MGIPC_PARAMS_SVH
`define MGIPC_PARAMS_SVH
`define MGIPC_OFS_GLOBAL 11'h40a
`define MGIPC_OFS_IAC 11'h4a0
`define MGIPC_OFS_IRS 11'h4a2
`define MGIPC_OFS_IDH 11'h4a4
`define MGIPC_OFS_IDS 11'h4a6
`define MGIPC_OFS_IDL 11'h4a8
`define MGIPC_OFS_IDM 11'h4aa
`define MGIPC_OFS_PHY 11'h4d0
`define MGIPC_OFS_PC4 11'h4d8
`define MGIPC_LED_HI_BIT 15
`define MGIPC_LED_LO_BIT 9
`define MGIPC_IAC_DIR_BIT 12
`define MGIPC_IAC_TBL_HI 11
`define MGIPC_IAC_TBL_LO 10
`define MGIPC_IAC_ADR_HI 9
`define MGIPC_IRS_BUSY_BIT 7
`define MGIPC_TBL_COUNTERS 2'h3
`define MGIPC_PHY_SPEED_BIT 13
`define MGIPC_PHY_AN_BIT 12
`define MGIPC_PHY_PWD_BIT 11
`define MGIPC_PHY_RST_AN_BIT 9
`define MGIPC_PHY_DPX_BIT 8
`define MGIPC_PHY_ALTX_BIT 5
`define MGIPC_PHY_FMDIX_BIT 4
`define MGIPC_PHY_NOMDIX_BIT 3
`define MGIPC_PHY_NOFEF_BIT 2
`define MGIPC_PHY_NOTX_BIT 1
`define MGIPC_PHY_NOLED_BIT 0
`define MGIPC_PHY_RESET 16'h1000
`define MGIPC_GLOBAL_RESET 16'h0000
`define MGIPC_GLOBAL_WMASK 16'h8200
`define MGIPC_IAC_RESET 16'h0000
`define MGIPC_IAC_WMASK 16'h1fff
`define MGIPC_DATA_RESET 16'h0000
`define MGIPC_READ_LAT 4'h4
`endif

// file: src/mgipc_pkg.sv
// Types shared by the control bank
package mgipc_pkg;
    typedef enum logic [2:0] {
        MGIPC_IDLE = 3'b001,
        MGIPC_RD = 3'b010,
        MGIPC_WR = 3'b100
    } mgipc_cmd_state_t;
endpackage

// file: src/mgipc_regs.sv
// Global, indirect access and PHY basic control register bank
//
// Behaviour
// - Global bits 15 and 9 pick LED mode
// - Writing indirect control launches one command
// - Indirect bit 12: one reads, zero writes
// - Bits 11-10 pick table, 11 counters
// - Bits 9-0 hold entry address, reset zero
// - Status bit 7 high while read pending
// - Second data register holds bits 47-32
// - Fourth holds 15-0, fifth holds 31-16
// - Bit 13 forces speed without autoneg
// - Bit 12 enables autoneg, resets to one
// - Writing one to bit 9 restarts autoneg
// - Bit 8 forces duplex without autoneg
// - Bit 5 picks alternate crossover, reset zero
// - Bit 3 disables automatic crossover
// - Bit 2 disables far-end fault detection
`timescale 1ns/10ps
`include "mgipc_params.svh"
module mgipc_regs (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [10:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic cnt_req_o,
    output logic cnt_rd_o,
    output logic [1:0] cnt_table_o,
    output logic [9:0] cnt_addr_o,
    output logic [47:0] cnt_wdata_o,
    input wire logic cnt_ack_i,
    input wire logic [47:0] cnt_rdata_i,
    input wire logic link_i,
    input wire logic act_i,
    input wire logic speed100_i,
    input wire logic full_dpx_i,
    input wire logic col_i,
    output logic [3:0] port_indicator_o,
    output logic an_enable_o,
    output logic an_restart_o,
    output logic force_100_o,
    output logic force_full_o,
    output logic power_down_o,
    output logic alt_crossover_mode_o,
    output logic force_mdix_o,
    output logic mdix_disable_o,
    output logic fef_disable_o,
    output logic tx_disable_o,
    output logic led_disable_o
);
    // Stored register contents
    logic [15:0] global_q;
    logic [15:0] iac_q;
    logic [15:0] data_high_q;
    logic [15:0] data_spare_q;
    logic [15:0] data_low_q;
    logic [15:0] data_mid_q;
    logic [15:0] phy_q;
    // Command tracking
    logic busy_q; // Read status seen by software
    logic req_q; // Request level towards the counter table
    logic restart_q; // One-cycle autoneg restart pulse
    // Output flops
    logic [15:0] rdata_q; // Read answer, one cycle after the strobe
    logic [3:0] led_q; // Indicator drive
    mgipc_pkg::mgipc_cmd_state_t state_q; // Kind of command in flight
    // Decoded strobes
    logic wr_global; // Write to global control
    logic wr_iac; // Write to indirect control
    logic wr_phy; // Write to PHY control
    logic wr_pc4; // Write to port control four
    logic [15:0] pc4_view; // Read image of port control four
    logic [1:0] led_mode; // Bit 15 and bit 9 of global control

    // Address decode needs an exact match; other offsets are ignored
    assign wr_global = reg_wr_i && (reg_addr_i == `MGIPC_OFS_GLOBAL);
    assign wr_iac = reg_wr_i && (reg_addr_i == `MGIPC_OFS_IAC);
    assign wr_phy = reg_wr_i && (reg_addr_i == `MGIPC_OFS_PHY);
    assign wr_pc4 = reg_wr_i && (reg_addr_i == `MGIPC_OFS_PC4);
    // LED mode comes straight from the stored select bits
    assign led_mode = {global_q[`MGIPC_LED_HI_BIT], global_q[`MGIPC_LED_LO_BIT]};

    // Port control four is a second view of the PHY control bits, same flops
    // Keeping one set of flops means the two views can never disagree
    // The alternate crossover bit has no place in this view
    assign pc4_view = {phy_q[`MGIPC_PHY_NOLED_BIT], phy_q[`MGIPC_PHY_NOTX_BIT],
                       restart_q, phy_q[`MGIPC_PHY_NOFEF_BIT],
                       phy_q[`MGIPC_PHY_PWD_BIT], phy_q[`MGIPC_PHY_NOMDIX_BIT],
                       phy_q[`MGIPC_PHY_FMDIX_BIT], 1'b0,
                       phy_q[`MGIPC_PHY_AN_BIT], phy_q[`MGIPC_PHY_SPEED_BIT],
                       phy_q[`MGIPC_PHY_DPX_BIT], 5'h00};

    // Global control: only the LED select bits are kept
    // Reserved bits read back as zero; no logic listens to them
    // so storing them would only cost flops
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            global_q <= `MGIPC_GLOBAL_RESET;
        end else if (wr_global) begin
            global_q <= reg_wdata_i & `MGIPC_GLOBAL_WMASK;
        end
    end

    // A global write keeps exactly the two select bits, both of them
    led_store_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_global |=> led_mode == {$past(reg_wdata_i[15]), $past(reg_wdata_i[9])})
        else $error("LED select bits not stored");

    // Indirect control: captured on every write, fields drive the command
    // Bits 15-13 are masked off so they always read zero
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            iac_q <= `MGIPC_IAC_RESET;
        end else if (wr_iac) begin
            // Kept for a write command too, so software can read it back
            iac_q <= reg_wdata_i & `MGIPC_IAC_WMASK;
        end
    end

    // The table and address fields follow the write that launched the command
    table_sel_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_iac |=> cnt_table_o == $past(reg_wdata_i[11:10]))
        else $error("table select not taken");

    // Command launcher; a write during a pending read restarts with the new fields
    // Trade-off: the old command is dropped without an answer, which keeps
    // the launcher small; software is expected to wait for busy to clear
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state_q <= mgipc_pkg::MGIPC_IDLE;
            req_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (wr_iac) begin
            req_q <= 1'b1;
            // Busy only shows for reads; a table write has no status
            if (reg_wdata_i[`MGIPC_IAC_DIR_BIT]) begin
                state_q <= mgipc_pkg::MGIPC_RD;
                busy_q <= 1'b1;
            end else begin
                state_q <= mgipc_pkg::MGIPC_WR;
                busy_q <= 1'b0;
            end
        end else begin
            unique case (state_q)
                // Nothing pending
                mgipc_pkg::MGIPC_IDLE: begin
                    req_q <= 1'b0;
                end
                // Hold the request until the table answers
                mgipc_pkg::MGIPC_RD, mgipc_pkg::MGIPC_WR: begin
                    if (cnt_ack_i) begin
                        state_q <= mgipc_pkg::MGIPC_IDLE;
                        req_q <= 1'b0;
                        busy_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // A write always raises the request, whatever the direction
    launch_cmd_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_iac |=> cnt_req_o && cnt_addr_o == $past(reg_wdata_i[9:0]))
        else $error("indirect write did not launch command");
    read_dir_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_iac && reg_wdata_i[12] |=> cnt_rd_o && busy_q)
        else $error("read direction not taken");
    write_dir_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_iac && !reg_wdata_i[12] |=> !cnt_rd_o && !busy_q)
        else $error("write direction not taken");
    // Busy must drop at the answer, and the request holds until then
    busy_clear_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        state_q == mgipc_pkg::MGIPC_RD && cnt_ack_i && !wr_iac |=> !busy_q)
        else $error("busy not cleared after ack");
    req_hold_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        cnt_req_o && !cnt_ack_i |=> cnt_req_o)
        else $error("request dropped before answer");

    // Data word: software writes stage a table write, a read answer loads all three
    // The answer wins over a software write in the same cycle; the spare
    // register only stores what software writes
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            data_high_q <= `MGIPC_DATA_RESET;
            data_spare_q <= `MGIPC_DATA_RESET;
            data_low_q <= `MGIPC_DATA_RESET;
            data_mid_q <= `MGIPC_DATA_RESET;
        end else if (state_q == mgipc_pkg::MGIPC_RD && cnt_ack_i && !wr_iac) begin
            data_high_q <= cnt_rdata_i[47:32];
            data_mid_q <= cnt_rdata_i[31:16];
            data_low_q <= cnt_rdata_i[15:0];
        end else if (reg_wr_i) begin
            // Plain software writes to the data registers
            if (reg_addr_i == `MGIPC_OFS_IDH) begin
                data_high_q <= reg_wdata_i;
            end
            if (reg_addr_i == `MGIPC_OFS_IDS) begin
                data_spare_q <= reg_wdata_i;
            end
            if (reg_addr_i == `MGIPC_OFS_IDL) begin
                data_low_q <= reg_wdata_i;
            end
            if (reg_addr_i == `MGIPC_OFS_IDM) begin
                data_mid_q <= reg_wdata_i;
            end
        end
    end

    // All 48 bits land together, in word order
    data_load_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        state_q == mgipc_pkg::MGIPC_RD && cnt_ack_i && !wr_iac
        |=> cnt_wdata_o == $past(cnt_rdata_i))
        else $error("read answer not loaded");

    // PHY control, writable through both views except the alternate crossover bit, which only the PHY view writes
    // Isolate, soft reset and the reserved bits are not stored and read zero
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            phy_q <= `MGIPC_PHY_RESET;
        end else if (wr_phy) begin
            // Restart is not stored here; it has its own pulse
            phy_q[`MGIPC_PHY_SPEED_BIT] <= reg_wdata_i[`MGIPC_PHY_SPEED_BIT];
            phy_q[`MGIPC_PHY_AN_BIT] <= reg_wdata_i[`MGIPC_PHY_AN_BIT];
            phy_q[`MGIPC_PHY_PWD_BIT] <= reg_wdata_i[`MGIPC_PHY_PWD_BIT];
            phy_q[`MGIPC_PHY_DPX_BIT] <= reg_wdata_i[`MGIPC_PHY_DPX_BIT];
            phy_q[`MGIPC_PHY_ALTX_BIT] <= reg_wdata_i[`MGIPC_PHY_ALTX_BIT];
            phy_q[`MGIPC_PHY_FMDIX_BIT] <= reg_wdata_i[`MGIPC_PHY_FMDIX_BIT];
            phy_q[`MGIPC_PHY_NOMDIX_BIT] <= reg_wdata_i[`MGIPC_PHY_NOMDIX_BIT];
            phy_q[`MGIPC_PHY_NOFEF_BIT] <= reg_wdata_i[`MGIPC_PHY_NOFEF_BIT];
            phy_q[`MGIPC_PHY_NOTX_BIT] <= reg_wdata_i[`MGIPC_PHY_NOTX_BIT];
            phy_q[`MGIPC_PHY_NOLED_BIT] <= reg_wdata_i[`MGIPC_PHY_NOLED_BIT];
        end else if (wr_pc4) begin
            // Same flops as above, laid out at the port view's positions
            phy_q[`MGIPC_PHY_SPEED_BIT] <= reg_wdata_i[6];
            phy_q[`MGIPC_PHY_AN_BIT] <= reg_wdata_i[7];
            phy_q[`MGIPC_PHY_PWD_BIT] <= reg_wdata_i[11];
            phy_q[`MGIPC_PHY_DPX_BIT] <= reg_wdata_i[5];
            phy_q[`MGIPC_PHY_FMDIX_BIT] <= reg_wdata_i[9];
            phy_q[`MGIPC_PHY_NOMDIX_BIT] <= reg_wdata_i[10];
            phy_q[`MGIPC_PHY_NOFEF_BIT] <= reg_wdata_i[12];
            phy_q[`MGIPC_PHY_NOTX_BIT] <= reg_wdata_i[14];
            phy_q[`MGIPC_PHY_NOLED_BIT] <= reg_wdata_i[15];
        end
    end

    // Forced speed and duplex follow the written bits once autoneg is off
    speed_force_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_phy && !reg_wdata_i[12] |=> force_100_o == $past(reg_wdata_i[13]))
        else $error("speed forced wrongly");
    dpx_force_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_phy && !reg_wdata_i[12] |=> force_full_o == $past(reg_wdata_i[8]))
        else $error("duplex forced wrongly");
    // With autoneg on, neither speed nor duplex may be forced
    an_write_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_phy |=> an_enable_o == $past(reg_wdata_i[12])
        && (!an_enable_o || (!force_100_o && !force_full_o)))
        else $error("autoneg enable not stored");
    altx_store_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_phy |=> alt_crossover_mode_o == $past(reg_wdata_i[5]))
        else $error("crossover variant not stored");
    mdix_dis_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_phy |=> mdix_disable_o == $past(reg_wdata_i[3])
        && fef_disable_o == $past(reg_wdata_i[2]))
        else $error("disable bits not stored");
    // The second view writes the same flops, so the first view sees it
    shared_view_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_pc4 |=> an_enable_o == $past(reg_wdata_i[7]))
        else $error("shared view mismatch");

    // Restart is a one-cycle pulse; writing zero does nothing
    // Registered so the pulse is clean, at the cost of one cycle of delay
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            restart_q <= 1'b0;
        end else begin
            // Either view may request the restart
            restart_q <= (wr_phy && reg_wdata_i[`MGIPC_PHY_RST_AN_BIT])
                      || (wr_pc4 && reg_wdata_i[13]);
        end
    end

    // Restart pulses once; a second write in the next cycle may pulse again
    restart_pulse_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_phy && reg_wdata_i[9] |=> an_restart_o ##1
        (!an_restart_o || $past(wr_phy && reg_wdata_i[9] || wr_pc4 && reg_wdata_i[13])))
        else $error("restart not one pulse");
    restart_idle_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        !(wr_phy && reg_wdata_i[9]) && !(wr_pc4 && reg_wdata_i[13]) |=> !an_restart_o)
        else $error("restart without request");
    pc4_restart_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        wr_pc4 && reg_wdata_i[13] |=> an_restart_o)
        else $error("restart through port view lost");

    // LED mapping; mode 11 is undefined and leaves the indicators dark
    // Registered, so the indicators lag the status inputs by one cycle
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            led_q <= 4'h0;
        end else begin
            unique case (led_mode)
                2'h0: led_q <= {1'b0, link_i & ~act_i | link_i & act_i,
                                full_dpx_i | col_i, speed100_i};
                2'h1: led_q <= {1'b0, link_i & speed100_i, link_i & ~speed100_i,
                                full_dpx_i};
                2'h2: led_q <= {act_i, link_i, full_dpx_i | col_i, speed100_i};
                // Undefined mode: dark rather than guessing
                2'h3: led_q <= 4'h0;
            endcase
        end
    end

    // Mode 10 shows activity, link and speed on their own indicators, duplex and collision on one shared
    led_act_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        led_mode == 2'h2 |=> port_indicator_o
        == $past({act_i, link_i, full_dpx_i | col_i, speed100_i}))
        else $error("LED mode 10 pattern wrong");
    // Mode 11 has no meaning, so the indicators stay dark
    led_dark_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        led_mode == 2'h3 |=> port_indicator_o == 4'h0)
        else $error("LED mode 11 not dark");

    // Read data one cycle after the strobe; unmapped reads return zero
    // The status bit is read live, so polling sees the answer at once
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd_i) begin
            // Exact offsets only; everything else reads zero
            unique case (reg_addr_i)
                `MGIPC_OFS_GLOBAL: rdata_q <= global_q;
                `MGIPC_OFS_IAC: rdata_q <= iac_q;
                `MGIPC_OFS_IRS: rdata_q <= {8'h00, busy_q, 7'h00};
                `MGIPC_OFS_IDH: rdata_q <= data_high_q;
                `MGIPC_OFS_IDS: rdata_q <= data_spare_q;
                `MGIPC_OFS_IDL: rdata_q <= data_low_q;
                `MGIPC_OFS_IDM: rdata_q <= data_mid_q;
                `MGIPC_OFS_PHY: rdata_q <= {2'h0, phy_q[13:10], restart_q, phy_q[8:0]};
                `MGIPC_OFS_PC4: rdata_q <= pc4_view;
                default: rdata_q <= 16'h0000;
            endcase
        end else begin
            // Outside a read cycle the bus shows zero
            rdata_q <= 16'h0000;
        end
    end

    // Read data stand one cycle only; the bus sees zero otherwise
    rdata_idle_a: assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
        !reg_rd_i |=> reg_rdata_o == 16'h0000)
        else $error("read data outside read cycle");

    // Outputs: command fields come straight from the stored control word
    assign reg_rdata_o = rdata_q;
    assign cnt_req_o = req_q;
    assign cnt_rd_o = iac_q[`MGIPC_IAC_DIR_BIT];
    assign cnt_table_o = iac_q[`MGIPC_IAC_TBL_HI:`MGIPC_IAC_TBL_LO];
    assign cnt_addr_o = iac_q[`MGIPC_IAC_ADR_HI:0];
    assign cnt_wdata_o = {data_high_q, data_mid_q, data_low_q};
    assign port_indicator_o = led_q;
    assign an_enable_o = phy_q[`MGIPC_PHY_AN_BIT];
    assign an_restart_o = restart_q;
    // Forced values only matter when autoneg is off
    // so the output already carries the gate, not the raw bit
    assign force_100_o = ~phy_q[`MGIPC_PHY_AN_BIT] & phy_q[`MGIPC_PHY_SPEED_BIT];
    assign force_full_o = ~phy_q[`MGIPC_PHY_AN_BIT] & phy_q[`MGIPC_PHY_DPX_BIT];
    assign power_down_o = phy_q[`MGIPC_PHY_PWD_BIT];
    assign alt_crossover_mode_o = phy_q[`MGIPC_PHY_ALTX_BIT];
    assign force_mdix_o = phy_q[`MGIPC_PHY_FMDIX_BIT];
    assign mdix_disable_o = phy_q[`MGIPC_PHY_NOMDIX_BIT];
    assign fef_disable_o = phy_q[`MGIPC_PHY_NOFEF_BIT];
    assign tx_disable_o = phy_q[`MGIPC_PHY_NOTX_BIT];
    assign led_disable_o = phy_q[`MGIPC_PHY_NOLED_BIT];

endmodule // mgipc_regs

// file: bench/mgipc_regs_bench.sv
// Self-checking bench for the global, indirect access and PHY control bank
`timescale 1ns/10ps
`include "mgipc_params.svh"
module mgipc_regs_bench;
    logic ref_clk_i = 1'b0; // 200 MHz core clock
    logic nrst_i = 1'b0; // Sync reset, active low
    logic [10:0] reg_addr_i = 11'h000;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic cnt_req_o, cnt_rd_o;
    logic [1:0] cnt_table_o;
    logic [9:0] cnt_addr_o;
    logic [47:0] cnt_wdata_o;
    logic cnt_ack_i = 1'b0; // Counter table answer pulse
    logic [47:0] cnt_rdata_i = 48'h000000000000;
    logic link_i = 1'b0, act_i = 1'b0, speed100_i = 1'b0, full_dpx_i = 1'b0, col_i = 1'b0;
    logic [3:0] port_indicator_o;
    logic an_enable_o, an_restart_o, force_100_o, force_full_o, power_down_o;
    logic alt_crossover_mode_o, force_mdix_o, mdix_disable_o, fef_disable_o;
    logic tx_disable_o, led_disable_o;
    int miscompares = 0; // Mismatches seen
    int n_compared = 0; // Comparisons made
    int cycles = 0; // Watchdog count
    logic [15:0] rd_val; // Last read answer
    logic [1:0] m; // LED mode under test
    logic [4:0] st; // Status pattern {link,act,spd,fd,col}

    mgipc_regs mgipc_regs_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .cnt_req_o(cnt_req_o),
        .cnt_rd_o(cnt_rd_o), .cnt_table_o(cnt_table_o), .cnt_addr_o(cnt_addr_o),
        .cnt_wdata_o(cnt_wdata_o), .cnt_ack_i(cnt_ack_i), .cnt_rdata_i(cnt_rdata_i),
        .link_i(link_i), .act_i(act_i), .speed100_i(speed100_i), .full_dpx_i(full_dpx_i),
        .col_i(col_i), .port_indicator_o(port_indicator_o), .an_enable_o(an_enable_o),
        .an_restart_o(an_restart_o), .force_100_o(force_100_o),
        .force_full_o(force_full_o), .power_down_o(power_down_o),
        .alt_crossover_mode_o(alt_crossover_mode_o), .force_mdix_o(force_mdix_o),
        .mdix_disable_o(mdix_disable_o), .fef_disable_o(fef_disable_o),
        .tx_disable_o(tx_disable_o), .led_disable_o(led_disable_o));

    // Free-running clock, 5 ns period
    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    // Watchdog: the whole run needs well under a thousand cycles
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            give_verdict();
        end
    end

    // Compare one value against its expectation
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe; effect visible just after the returning edge
    task automatic wr(input logic [10:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask

    // One-cycle read strobe; the answer stands only in the following cycle
    task automatic rd(input logic [10:0] a);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        rd_val = reg_rdata_o;
    endtask

    task automatic rd_chk(input logic [10:0] a, input logic [15:0] exp);
        rd(a);
        chk({32'h0, rd_val}, {32'h0, exp});
    endtask

    // Indicator pattern per LED mode; mode 11 leaves all dark
    function automatic logic [3:0] led_exp(input logic [1:0] md, input logic [4:0] s);
        logic lk, ac, sp, fd, cl;
        {lk, ac, sp, fd, cl} = s;
        case (md)
            2'h0: led_exp = {1'b0, lk, fd | cl, sp};
            2'h1: led_exp = {1'b0, lk & sp, lk & ~sp, fd};
            2'h2: led_exp = {ac, lk, fd | cl, sp};
            default: led_exp = 4'h0;
        endcase
    endfunction

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        chk(an_enable_o, 1'b1);
        rd_chk(`MGIPC_OFS_PHY, 16'h1000);
        rd_chk(`MGIPC_OFS_IAC, 16'h0000);
        rd_chk(`MGIPC_OFS_IDH, 16'h0000);
        rd_chk(`MGIPC_OFS_IDL, 16'h0000);
        rd_chk(`MGIPC_OFS_IDM, 16'h0000);
        rd_chk(11'h4c0, 16'h0000);
        $display("test reset values done");
        wr(`MGIPC_OFS_GLOBAL, 16'hffff);
        rd_chk(`MGIPC_OFS_GLOBAL, 16'h8200);
        // Every LED mode against two status patterns
        for (int i = 0; i < 8; i++) begin
            m = i[2:1];
            st = i[0] ? 5'b10110 : 5'b11001;
            wr(`MGIPC_OFS_GLOBAL, {m[1], 5'h00, m[0], 9'h000});
            {link_i, act_i, speed100_i, full_dpx_i, col_i} <= st;
            repeat (2) @(posedge ref_clk_i);
            #1;
            chk(port_indicator_o, led_exp(m, st));
        end
        $display("test led modes done");
        // Indirect write command carries the data word
        wr(`MGIPC_OFS_IDH, 16'h1111);
        wr(`MGIPC_OFS_IDM, 16'h2222);
        wr(`MGIPC_OFS_IDL, 16'h3333);
        wr(`MGIPC_OFS_IDS, 16'habcd);
        wr(`MGIPC_OFS_IAC, 16'h0c07);
        chk({cnt_req_o, cnt_rd_o, cnt_table_o, cnt_addr_o}, {4'b1011, 10'h007});
        chk(cnt_wdata_o, 48'h111122223333);
        rd_chk(`MGIPC_OFS_IDS, 16'habcd);
        @(posedge ref_clk_i);
        cnt_ack_i <= 1'b1;
        @(posedge ref_clk_i);
        cnt_ack_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk(cnt_req_o, 1'b0);
        // Counter read: busy until the table answers, then data lands
        wr(`MGIPC_OFS_IAC, 16'hfc05);
        chk({cnt_req_o, cnt_rd_o, cnt_table_o, cnt_addr_o}, 14'h3c05);
        rd_chk(`MGIPC_OFS_IAC, 16'h1c05);
        rd_chk(`MGIPC_OFS_IRS, 16'h0080);
        @(posedge ref_clk_i);
        cnt_ack_i <= 1'b1;
        cnt_rdata_i <= 48'h123456789abc;
        @(posedge ref_clk_i);
        cnt_ack_i <= 1'b0;
        cnt_rdata_i <= 48'hedcba9876543;
        rd_val = 16'h0080;
        // Poll the status bit a bounded number of times
        for (int k = 0; k < 20 && rd_val[7] !== 1'b0; k++) rd(`MGIPC_OFS_IRS);
        chk({32'h0, rd_val}, 48'h0);
        rd_chk(`MGIPC_OFS_IDH, 16'h1234);
        rd_chk(`MGIPC_OFS_IDM, 16'h5678);
        rd_chk(`MGIPC_OFS_IDL, 16'h9abc);
        $display("test indirect access done");
        // Forced speed and duplex apply only with auto-negotiation off
        wr(`MGIPC_OFS_PHY, 16'h2100);
        chk({an_enable_o, force_100_o, force_full_o}, 3'b011);
        rd_chk(`MGIPC_OFS_PC4, 16'h0060);
        wr(`MGIPC_OFS_PHY, 16'h3100);
        chk({an_enable_o, force_100_o, force_full_o}, 3'b100);
        wr(`MGIPC_OFS_PHY, 16'h0200);
        chk(an_restart_o, 1'b1);
        @(posedge ref_clk_i);
        #1;
        chk(an_restart_o, 1'b0);
        wr(`MGIPC_OFS_PHY, 16'h002c);
        chk({alt_crossover_mode_o, force_mdix_o}, 2'h2);
        chk({mdix_disable_o, fef_disable_o}, 2'h3);
        rd_chk(`MGIPC_OFS_PC4, 16'h1400);
        wr(`MGIPC_OFS_PC4, 16'h8080);
        chk({an_enable_o, led_disable_o, mdix_disable_o, fef_disable_o}, 4'hc);
        chk(alt_crossover_mode_o, 1'b1);
        wr(`MGIPC_OFS_PHY, 16'h0803);
        chk({power_down_o, tx_disable_o, led_disable_o, an_enable_o}, 4'he);
        rd_chk(`MGIPC_OFS_PC4, 16'hc800);
        wr(`MGIPC_OFS_PC4, 16'h2000);
        chk(an_restart_o, 1'b1);
        $display("test phy control done");
        // Mid-run reset brings back the reset values
        @(posedge ref_clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        #1;
        chk({cnt_req_o, an_enable_o, an_restart_o, power_down_o}, 4'h4);
        rd_chk(`MGIPC_OFS_PHY, 16'h1000);
        rd_chk(`MGIPC_OFS_IDH, 16'h0000);
        rd_chk(`MGIPC_OFS_IAC, 16'h0000);
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule // mgipc_regs_bench
